/* rtl/rtcc_core.sv */
// Timekeeping core: BCD calendar counters, one alarm, oscillator watchdog, square-wave output.
// Assumes the two-wire framing engine sits on clock and drives the byte-level register port;
// osc_clk is the crystal oscillator clock and is unrelated to clock.
`timescale 1ns/100ps
`default_nettype none

module rtcc_core #(
  parameter int OSC_FAIL_CYCLES = rtcc_pkg::OSC_FAIL_CYCLES
) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 osc_clk,
  input  wire rtcc_pkg::rtcc_req_type reg_req,
  output var  rtcc_pkg::rtcc_rsp_type reg_rsp,
  input  wire logic                 square_wave_pin_i,
  output wire logic                 square_wave_pin_o,
  output wire logic                 square_wave_pin_oe,
  input  wire logic                 alarm_irq_pin_i,
  output wire logic                 alarm_irq_pin_o,
  output wire logic                 alarm_irq_pin_oe
);

  logic [7:0] ptr_r;
  logic [7:0] sec_r, min_r, hr_r, date_r, wday_r, mon_r, yr_r;
  logic [7:0] amin_r, ahr_r, adat_r, awdy_r;
  logic       osf_r, af_r, aie_r, square_wave_enable_r;
  logic [1:0] rs_r;
  logic [7:0] rd_data_r, rd_mux;
  logic       hit;

  function automatic logic [7:0] bcd_next(input logic [7:0] v, input logic [7:0] last,
                                          input logic [7:0] first);
    if (v == last)
      return first;
    else if (v[3:0] == 4'h9)
      return {v[7:4] + 4'h1, 4'h0};
    else
      return v + 8'h01;
  endfunction

  // Oscillator domain: prescaler, seconds toggle and the square-wave pin.
  logic [rtcc_pkg::PRESCALE_W-1:0] pre_r;
  logic       sec_tgl_r;
  logic       en_s1_r, en_s2_r;
  logic [1:0] rs_s1_r, rs_s2_r;
  logic       wave;

  always_ff @(posedge osc_clk or posedge rst) begin
    if (rst) begin
      pre_r     <= '0;
      sec_tgl_r <= 1'b0;
    end else begin
      pre_r <= pre_r + 15'h0001;
      if (&pre_r)
        sec_tgl_r <= ~sec_tgl_r;
    end
  end

  // Configuration crosses as levels. The two rate bits may disagree for one oscillator
  // cycle after a change, which only shortens one half-period of the output.
  always_ff @(posedge osc_clk or posedge rst) begin
    if (rst) begin
      en_s1_r <= rtcc_pkg::RST_SQUARE_WAVE_ENABLE;
      en_s2_r <= rtcc_pkg::RST_SQUARE_WAVE_ENABLE;
      rs_s1_r <= rtcc_pkg::RST_RS;
      rs_s2_r <= rtcc_pkg::RST_RS;
    end else begin
      en_s1_r <= square_wave_enable_r;
      en_s2_r <= en_s1_r;
      rs_s1_r <= rs_r;
      rs_s2_r <= rs_s1_r;
    end
  end

  always_comb begin
    unique case (rs_s2_r)
      rtcc_pkg::RS_32K:  wave = osc_clk;
      rtcc_pkg::RS_1K:   wave = pre_r[rtcc_pkg::TAP_1K];
      rtcc_pkg::RS_32HZ: wave = pre_r[rtcc_pkg::TAP_32HZ];
      rtcc_pkg::RS_1HZ:  wave = pre_r[rtcc_pkg::TAP_1HZ];
    endcase
  end

  // Open drain: pull low on the low half of the wave, release otherwise or when disabled.
  assign square_wave_pin_o  = 1'b0;
  assign square_wave_pin_oe = en_s2_r & ~wave;

  // System domain: synchronisers for the seconds toggle and the oscillator heartbeat.
  logic [2:0] sec_sync_r;
  logic [2:0] beat_sync_r;
  logic       tick, beat;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sec_sync_r  <= 3'h0;
      beat_sync_r <= 3'h0;
    end else begin
      sec_sync_r  <= {sec_sync_r[1:0], sec_tgl_r};
      beat_sync_r <= {beat_sync_r[1:0], pre_r[rtcc_pkg::TAP_BEAT]};
    end
  end

  assign tick = sec_sync_r[2] ^ sec_sync_r[1];
  assign beat = beat_sync_r[2] ^ beat_sync_r[1];

  // Watchdog on the heartbeat; saturates so a dead oscillator keeps the flag asserted.
  logic [rtcc_pkg::WD_W-1:0] wd_r;
  logic                      osc_dead;
  assign osc_dead = (wd_r >= rtcc_pkg::WD_W'(OSC_FAIL_CYCLES));

  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      wd_r <= '0;
    else if (beat)
      wd_r <= '0;
    else if (!osc_dead)
      wd_r <= wd_r + 16'h0001;
  end

  // Register port.
  logic wr_ok;
  assign hit   = (ptr_r <= rtcc_pkg::ADDR_LAST);
  assign wr_ok = reg_req.wr && hit;

  function automatic logic wr_at(input logic ok, input logic [7:0] p, input logic [7:0] a);
    return ok && (p == a);
  endfunction

  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      ptr_r <= 8'h00;
    else if (reg_req.ptr_load)
      ptr_r <= reg_req.data;
    else if (reg_req.wr || reg_req.rd_next)
      ptr_r <= ptr_r + 8'h01;
  end

  // Counter chain, all BCD.
  logic       min_in, hr_in, day_in, mon_in, yr_in;
  logic       leap;
  logic [7:0] date_last;

  assign leap = yr_r[4] ? (yr_r[3:0] == 4'h2 || yr_r[3:0] == 4'h6)
                        : (yr_r[3:0] == 4'h0 || yr_r[3:0] == 4'h4 || yr_r[3:0] == 4'h8);

  always_comb begin
    if (mon_r == rtcc_pkg::MON_FEB)
      date_last = leap ? rtcc_pkg::DAYS_LEAP : rtcc_pkg::DAYS_FEB;
    else if (mon_r == rtcc_pkg::MON_APR || mon_r == rtcc_pkg::MON_JUN ||
             mon_r == rtcc_pkg::MON_SEP || mon_r == rtcc_pkg::MON_NOV)
      date_last = rtcc_pkg::DAYS_SHORT;
    else
      date_last = rtcc_pkg::DAYS_LONG;
  end

  assign min_in = tick && (sec_r == rtcc_pkg::SEC_LAST);
  assign hr_in  = min_in && (min_r == rtcc_pkg::MIN_LAST);
  assign day_in = hr_in && (hr_r == rtcc_pkg::HR_LAST);
  assign mon_in = day_in && (date_r == date_last);
  assign yr_in  = mon_in && (mon_r == rtcc_pkg::MON_LAST);

  // A host write to a counter wins over a tick in the same cycle.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sec_r  <= rtcc_pkg::RST_TIME;
      min_r  <= rtcc_pkg::RST_TIME;
      hr_r   <= rtcc_pkg::RST_TIME;
      date_r <= rtcc_pkg::RST_DATE;
      wday_r <= rtcc_pkg::RST_TIME;
      mon_r  <= rtcc_pkg::RST_MON;
      yr_r   <= rtcc_pkg::RST_TIME;
    end else begin
      if (wr_at(wr_ok, ptr_r, rtcc_pkg::ADDR_SEC))
        sec_r <= reg_req.data & rtcc_pkg::MASK_SEC;
      else if (tick)
        sec_r <= bcd_next(sec_r, rtcc_pkg::SEC_LAST, rtcc_pkg::ZERO_FIRST);
      if (wr_at(wr_ok, ptr_r, rtcc_pkg::ADDR_MIN))
        min_r <= reg_req.data & rtcc_pkg::MASK_MIN;
      else if (min_in)
        min_r <= bcd_next(min_r, rtcc_pkg::MIN_LAST, rtcc_pkg::ZERO_FIRST);
      if (wr_at(wr_ok, ptr_r, rtcc_pkg::ADDR_HR))
        hr_r <= reg_req.data & rtcc_pkg::MASK_HR;
      else if (hr_in)
        hr_r <= bcd_next(hr_r, rtcc_pkg::HR_LAST, rtcc_pkg::ZERO_FIRST);
      if (wr_at(wr_ok, ptr_r, rtcc_pkg::ADDR_DATE))
        date_r <= reg_req.data & rtcc_pkg::MASK_DATE;
      else if (day_in)
        date_r <= bcd_next(date_r, date_last, rtcc_pkg::ONE_FIRST);
      if (wr_at(wr_ok, ptr_r, rtcc_pkg::ADDR_WDAY))
        wday_r <= reg_req.data & rtcc_pkg::MASK_WDAY;
      else if (day_in)
        wday_r <= bcd_next(wday_r, rtcc_pkg::WDAY_LAST, rtcc_pkg::ZERO_FIRST);
      if (wr_at(wr_ok, ptr_r, rtcc_pkg::ADDR_MON))
        mon_r <= reg_req.data & rtcc_pkg::MASK_MON;
      else if (mon_in)
        mon_r <= bcd_next(mon_r, rtcc_pkg::MON_LAST, rtcc_pkg::ONE_FIRST);
      if (wr_at(wr_ok, ptr_r, rtcc_pkg::ADDR_YR))
        yr_r <= reg_req.data & rtcc_pkg::MASK_YR;
      else if (yr_in)
        yr_r <= bcd_next(yr_r, rtcc_pkg::YR_LAST, rtcc_pkg::ZERO_FIRST);
    end
  end

  // Alarm and control registers.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      amin_r <= rtcc_pkg::RST_ALARM;
      ahr_r  <= rtcc_pkg::RST_ALARM;
      adat_r <= rtcc_pkg::RST_ALARM;
      awdy_r <= rtcc_pkg::RST_ALARM;
      aie_r  <= rtcc_pkg::RST_AIE;
      square_wave_enable_r <= rtcc_pkg::RST_SQUARE_WAVE_ENABLE;
      rs_r   <= rtcc_pkg::RST_RS;
    end else begin
      if (wr_at(wr_ok, ptr_r, rtcc_pkg::ADDR_AMIN))
        amin_r <= reg_req.data & rtcc_pkg::MASK_AMIN;
      if (wr_at(wr_ok, ptr_r, rtcc_pkg::ADDR_AHR))
        ahr_r <= reg_req.data & rtcc_pkg::MASK_AHR;
      if (wr_at(wr_ok, ptr_r, rtcc_pkg::ADDR_ADAT))
        adat_r <= reg_req.data & rtcc_pkg::MASK_ADAT;
      if (wr_at(wr_ok, ptr_r, rtcc_pkg::ADDR_AWDY))
        awdy_r <= reg_req.data & rtcc_pkg::MASK_AWDY;
      if (wr_at(wr_ok, ptr_r, rtcc_pkg::ADDR_CS2))
        aie_r <= reg_req.data[rtcc_pkg::AIE_BIT];
      if (wr_at(wr_ok, ptr_r, rtcc_pkg::ADDR_SQW)) begin
        square_wave_enable_r <= reg_req.data[rtcc_pkg::SQUARE_WAVE_ENABLE_BIT];
        rs_r   <= reg_req.data[1:0];
      end
    end
  end

  // Oscillator-fail flag: hardware set wins over a host clear in the same cycle.
  logic osf_clr;
  assign osf_clr = wr_at(wr_ok, ptr_r, rtcc_pkg::ADDR_SEC) && !reg_req.data[rtcc_pkg::OSF_BIT];

  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      osf_r <= rtcc_pkg::RST_OSF;
    else if (osc_dead)
      osf_r <= 1'b1;
    else if (osf_clr)
      osf_r <= 1'b0;
  end

  // Alarm compare. Matching is judged right after a tick against the state before it,
  // so a match that merely persists, or one made by writing the alarm outside the cycle of a tick, never re-arms the flag.
  logic m_min, m_hr, m_date, m_wday, match_all;
  logic tick_d_r, pre_match_r, af_set, af_clr;

  assign m_min  = amin_r[rtcc_pkg::AE_BIT] || (amin_r[6:0] == min_r[6:0]);
  assign m_hr   = ahr_r[rtcc_pkg::AE_BIT]  || (ahr_r[5:0] == hr_r[5:0]);
  assign m_date = adat_r[rtcc_pkg::AE_BIT] || (adat_r[5:0] == date_r[5:0]);
  assign m_wday = awdy_r[rtcc_pkg::AE_BIT] || (awdy_r[2:0] == wday_r[2:0]);
  // With every field ignored there is nothing to match, so the alarm must stay quiet.
  assign match_all = m_min && m_hr && m_date && m_wday &&
                     !(amin_r[rtcc_pkg::AE_BIT] && ahr_r[rtcc_pkg::AE_BIT] &&
                       adat_r[rtcc_pkg::AE_BIT] && awdy_r[rtcc_pkg::AE_BIT]);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_d_r    <= 1'b0;
      pre_match_r <= 1'b0;
    end else begin
      tick_d_r <= tick;
      if (tick)
        pre_match_r <= match_all;
    end
  end

  assign af_set = tick_d_r && match_all && !pre_match_r;
  assign af_clr = wr_at(wr_ok, ptr_r, rtcc_pkg::ADDR_CS2) && !reg_req.data[rtcc_pkg::AF_BIT];

  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      af_r <= rtcc_pkg::RST_AF;
    else if (af_set)
      af_r <= 1'b1;
    else if (af_clr)
      af_r <= 1'b0;
  end

  assign alarm_irq_pin_o  = 1'b0;
  assign alarm_irq_pin_oe = af_r && aie_r;

  // Read data.
  always_comb begin
    unique case (ptr_r)
      rtcc_pkg::ADDR_CS2:  rd_mux = {4'h0, af_r, 1'b0, aie_r, 1'b0};
      rtcc_pkg::ADDR_SEC:  rd_mux = {osf_r, sec_r[6:0]};
      rtcc_pkg::ADDR_MIN:  rd_mux = min_r;
      rtcc_pkg::ADDR_HR:   rd_mux = hr_r;
      rtcc_pkg::ADDR_DATE: rd_mux = date_r;
      rtcc_pkg::ADDR_WDAY: rd_mux = wday_r;
      rtcc_pkg::ADDR_MON:  rd_mux = mon_r;
      rtcc_pkg::ADDR_YR:   rd_mux = yr_r;
      rtcc_pkg::ADDR_AMIN: rd_mux = amin_r;
      rtcc_pkg::ADDR_AHR:  rd_mux = ahr_r;
      rtcc_pkg::ADDR_ADAT: rd_mux = adat_r;
      rtcc_pkg::ADDR_AWDY: rd_mux = awdy_r;
      rtcc_pkg::ADDR_SQW:  rd_mux = {square_wave_enable_r, 5'h00, rs_r};
      default:             rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      rd_data_r <= 8'h00;
    else
      rd_data_r <= rd_mux;
  end

  always_comb begin
    reg_rsp.rd_data = rd_data_r;
    reg_rsp.hit     = hit;
  end

  // Checks.
  a_sec_wrap_carry: assert property (@(posedge clock) disable iff (rst)
    min_in && !wr_ok |=> sec_r == 8'h00 && min_r != $past(min_r))
    else $error("seconds did not wrap and carry");

  a_min_wrap_carry: assert property (@(posedge clock) disable iff (rst)
    hr_in && !wr_ok |=> min_r == 8'h00 && hr_r != $past(hr_r))
    else $error("minutes did not wrap and carry");

  a_hour_day_carry: assert property (@(posedge clock) disable iff (rst)
    day_in && !wr_ok |=> hr_r == 8'h00 && wday_r != $past(wday_r) && date_r != $past(date_r))
    else $error("hour wrap did not carry to date and weekday");

  a_wday_wrap: assert property (@(posedge clock) disable iff (rst)
    day_in && !wr_ok && wday_r == 8'h06 |=> wday_r == 8'h00)
    else $error("weekday did not wrap after 06");

  a_feb_plain_end: assert property (@(posedge clock) disable iff (rst)
    day_in && !wr_ok && mon_r == 8'h02 && date_r == 8'h28 && yr_r == 8'h01 |=> date_r == 8'h01 && mon_r == 8'h03)
    else $error("february of a plain year did not end at 28");

  a_feb_leap_day: assert property (@(posedge clock) disable iff (rst)
    day_in && !wr_ok && mon_r == 8'h02 && date_r == 8'h28 && yr_r == 8'h04 |=> date_r == 8'h29 && mon_r == 8'h02)
    else $error("leap year february skipped the 29th");

  a_year_wrap: assert property (@(posedge clock) disable iff (rst)
    yr_in && !wr_ok |=> yr_r == 8'h00 && mon_r == 8'h01)
    else $error("year did not wrap from 99");

  a_alarm_flag_hold: assert property (@(posedge clock) disable iff (rst)
    af_r && !af_clr |=> af_r)
    else $error("alarm flag dropped without a clear");

  a_alarm_flag_clear: assert property (@(posedge clock) disable iff (rst)
    af_clr && !af_set |=> !af_r ##1 (af_r == $past(af_set)))
    else $error("alarm flag clear misbehaved");

  a_alarm_no_rearm: assert property (@(posedge clock) disable iff (rst)
    !af_r && !tick_d_r |=> !af_r)
    else $error("alarm flag set without a time step");

  a_osf_sets: assert property (@(posedge clock) disable iff (rst)
    osc_dead |=> osf_r [*2])
    else $error("oscillator fail not flagged");

  a_ptr_advance: assert property (@(posedge clock) disable iff (rst)
    !reg_req.ptr_load && (reg_req.wr || reg_req.rd_next) |=> ptr_r == $past(ptr_r) + 8'h01)
    else $error("register pointer did not advance");

  a_no_answer_high: assert property (@(posedge clock) disable iff (rst)
    reg_req.ptr_load && reg_req.data > 8'h0f |=> !reg_rsp.hit)
    else $error("device answered beyond 0FH");

  a_irq_follows: assert property (@(posedge clock) disable iff (rst)
    af_set && aie_r |=> alarm_irq_pin_oe)
    else $error("interrupt pin not pulled on alarm");

  a_sqw_released: assert property (@(posedge osc_clk) disable iff (rst)
    !square_wave_enable_r [*3] |-> !square_wave_pin_oe)
    else $error("square-wave pin driven while disabled");

  c_alarm_fires: cover property (@(posedge clock) disable iff (rst) af_set);
  c_osc_fail: cover property (@(posedge clock) disable iff (rst) $rose(osf_r));
  c_leap_day: cover property (@(posedge clock) disable iff (rst) day_in && date_r == 8'h29);
  c_year_wrap: cover property (@(posedge clock) disable iff (rst) yr_in);

endmodule

`default_nettype wire

/* common/rtcc_pkg.sv */
// Constants, register map and carrier types for the BCD calendar and alarm core.
// Assumes a byte-level register port from a separate two-wire framing engine on the system clock.
//
// What this block does
// - Set oscillator-fail flag when oscillator stops.
// - Fail flag is seconds bit 7, resets 1.
// - Only addresses up to 0FH answer.
// - Alarm interrupt enable: reg 01 bit 1.
// - Alarm flag: write 0 clears, 1 keeps.
// - Square-wave enable 0 releases pin, default 1.
// - Rate select picks 32768, 1024, 32, 1 Hz.
// - All counters and alarm fields use BCD.
// - Seconds 00-59, carry into minutes.
// - Minutes 00-59, carry into hours.
// - Hours 00-23, carry into date, weekday.
// - Weekday counts 00 to 06, wraps.
// - Date wraps per month length, carries month.
// - February has 29 days in leap years.
// - Month 1-12 carries into year 00-99.
// - Alarm fields with bit 7 low compared.
// - Alarm fields with bit 7 high ignored.
// - Alarm flag set when matches first coincide.
// - Flag holds; re-set only on new match.
// - Interrupt pin is open-drain active low.
// - Register pointer advances after each byte.
// - Leap year is year divisible by four.

package rtcc_pkg;

  localparam logic [7:0] ADDR_CS1  = 8'h00;
  localparam logic [7:0] ADDR_CS2  = 8'h01;
  localparam logic [7:0] ADDR_SEC  = 8'h02;
  localparam logic [7:0] ADDR_MIN  = 8'h03;
  localparam logic [7:0] ADDR_HR   = 8'h04;
  localparam logic [7:0] ADDR_DATE = 8'h05;
  localparam logic [7:0] ADDR_WDAY = 8'h06;
  localparam logic [7:0] ADDR_MON  = 8'h07;
  localparam logic [7:0] ADDR_YR   = 8'h08;
  localparam logic [7:0] ADDR_AMIN = 8'h09;
  localparam logic [7:0] ADDR_AHR  = 8'h0a;
  localparam logic [7:0] ADDR_ADAT = 8'h0b;
  localparam logic [7:0] ADDR_AWDY = 8'h0c;
  localparam logic [7:0] ADDR_SQW  = 8'h0d;
  localparam logic [7:0] ADDR_LAST = 8'h0f;

  localparam int AF_BIT   = 3;
  localparam int AIE_BIT  = 1;
  localparam int OSF_BIT  = 7;
  localparam int AE_BIT   = 7;
  localparam int SQUARE_WAVE_ENABLE_BIT = 7;

  // Write masks: unimplemented bits are stored as zero and read back as zero.
  localparam logic [7:0] MASK_SEC  = 8'h7f;
  localparam logic [7:0] MASK_MIN  = 8'h7f;
  localparam logic [7:0] MASK_HR   = 8'h3f;
  localparam logic [7:0] MASK_DATE = 8'h3f;
  localparam logic [7:0] MASK_WDAY = 8'h07;
  localparam logic [7:0] MASK_MON  = 8'h1f;
  localparam logic [7:0] MASK_YR   = 8'hff;
  localparam logic [7:0] MASK_AMIN = 8'hff;
  localparam logic [7:0] MASK_AHR  = 8'hbf;
  localparam logic [7:0] MASK_ADAT = 8'hbf;
  localparam logic [7:0] MASK_AWDY = 8'h87;

  localparam logic [7:0] RST_TIME  = 8'h00;
  localparam logic [7:0] RST_DATE  = 8'h01;
  localparam logic [7:0] RST_MON   = 8'h01;
  localparam logic [7:0] RST_ALARM = 8'h80;
  localparam logic       RST_OSF   = 1'b1;
  localparam logic       RST_AF    = 1'b0;
  localparam logic       RST_AIE   = 1'b0;
  localparam logic       RST_SQUARE_WAVE_ENABLE  = 1'b1;
  localparam logic [1:0] RST_RS    = 2'h0;

  localparam logic [7:0] SEC_LAST   = 8'h59;
  localparam logic [7:0] MIN_LAST   = 8'h59;
  localparam logic [7:0] HR_LAST    = 8'h23;
  localparam logic [7:0] WDAY_LAST  = 8'h06;
  localparam logic [7:0] MON_LAST   = 8'h12;
  localparam logic [7:0] YR_LAST    = 8'h99;
  localparam logic [7:0] ZERO_FIRST = 8'h00;
  localparam logic [7:0] ONE_FIRST  = 8'h01;
  localparam logic [7:0] DAYS_LONG  = 8'h31;
  localparam logic [7:0] DAYS_SHORT = 8'h30;
  localparam logic [7:0] DAYS_FEB   = 8'h28;
  localparam logic [7:0] DAYS_LEAP  = 8'h29;
  localparam logic [7:0] MON_FEB    = 8'h02;
  localparam logic [7:0] MON_APR    = 8'h04;
  localparam logic [7:0] MON_JUN    = 8'h06;
  localparam logic [7:0] MON_SEP    = 8'h09;
  localparam logic [7:0] MON_NOV    = 8'h11;

  localparam logic [1:0] RS_32K  = 2'h0;
  localparam logic [1:0] RS_1K   = 2'h1;
  localparam logic [1:0] RS_32HZ = 2'h2;
  localparam logic [1:0] RS_1HZ  = 2'h3;
  localparam int PRESCALE_W = 15;
  localparam int TAP_1K     = 4;
  localparam int TAP_32HZ   = 9;
  localparam int TAP_1HZ    = 14;
  localparam int TAP_BEAT   = 3;

  localparam int CLK_HZ           = 10_000_000;
  localparam int OSC_FAIL_TIME_US = 1000;
  localparam int OSC_FAIL_CYCLES  = OSC_FAIL_TIME_US * (CLK_HZ / 1_000_000);
  localparam int WD_W             = 16;

  typedef struct packed {
    logic       ptr_load;
    logic       wr;
    logic       rd_next;
    logic [7:0] data;
  } rtcc_req_type;

  typedef struct packed {
    logic [7:0] rd_data;
    logic       hit;
  } rtcc_rsp_type;

endpackage

/* tb/rtcc_osc_model.sv */
// Far-side model: a crystal oscillator that can be stopped, and pull-ups on the open-drain pins.
// Assumes the bench holds run high except when it provokes an oscillator failure.
`timescale 1ns/100ps
`default_nettype none

module rtcc_osc_model (
  input  wire logic run,
  input  wire logic sqw_oe,
  input  wire logic irq_oe,
  output var  logic osc_clk,
  output wire logic sqw_pin,
  output wire logic irq_pin
);
  // A dead crystal leaves its clock standing still rather than toggling.
  initial begin
    osc_clk = 1'b0;
    forever #24 if (run) osc_clk = ~osc_clk;
  end
  // Released pins read high through the board pull-ups.
  assign sqw_pin = sqw_oe ? 1'b0 : 1'b1;
  assign irq_pin = irq_oe ? 1'b0 : 1'b1;
endmodule

`default_nettype wire

/* tb/bcd_calendar_alarm_core_tb.sv */
// Self-checking bench for the calendar and alarm core, driving the byte-level register port.
// Assumes the oscillator model in tb/ and a shortened oscillator-fail count of 200 clocks.
`timescale 1ns/100ps
`default_nettype none

module bcd_calendar_alarm_core_tb;
  logic                   clock;
  logic                   rst;
  logic                   run;
  logic                   prev;
  rtcc_pkg::rtcc_req_type req;
  rtcc_pkg::rtcc_rsp_type rsp;
  wire logic              osc_clk;
  wire logic              sqw_oe;
  wire logic              irq_oe;
  wire logic              sqw_pin;
  wire logic              irq_pin;
  int                     err_count;
  int                     tests_run;
  int                     cyc;
  int                     edges;
  int                     seed;
  int                     ex;
  logic [7:0]             v;
  logic [7:0]             got [14];

  rtcc_core #(.OSC_FAIL_CYCLES(200)) uut (
    .clock(clock), .rst(rst), .osc_clk(osc_clk), .reg_req(req), .reg_rsp(rsp),
    .square_wave_pin_i(sqw_pin), .square_wave_pin_o(), .square_wave_pin_oe(sqw_oe),
    .alarm_irq_pin_i(irq_pin), .alarm_irq_pin_o(), .alarm_irq_pin_oe(irq_oe));

  rtcc_osc_model far (.run(run), .sqw_oe(sqw_oe), .irq_oe(irq_oe), .osc_clk(osc_clk),
    .sqw_pin(sqw_pin), .irq_pin(irq_pin));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cmp(input logic [7:0] e[$]);
    foreach (e[i]) chk(got[i], e[i]);
  endtask

  // Every request gets an idle cycle after it, so no strobe is rewritten in one time step.
  task automatic put(input logic p, input logic w, input logic r, input logic [7:0] d);
    @(posedge clock);
    req <= '{p, w, r, d};
    @(posedge clock);
    req <= '0;
  endtask

  task automatic wrb(input logic [7:0] a, input logic [7:0] d[$]);
    put(1'b1, 1'b0, 1'b0, a);
    foreach (d[i]) put(1'b0, 1'b1, 1'b0, d[i]);
  endtask

  task automatic rdb(input logic [7:0] a, input int n);
    put(1'b1, 1'b0, 1'b0, a);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      #1 got[i] = rsp.rd_data;
      put(1'b0, 1'b0, 1'b1, 8'h00);
    end
  endtask

  // One wait covers exactly one seconds tick: longer than one period, shorter than two.
  task automatic one_second();
    repeat (16500) @(posedge clock);
  endtask

  task automatic count_wave(input logic [7:0] ctl);
    wrb(8'h0d, '{ctl});
    repeat (20) @(posedge clock);
    edges = 0;
    repeat (2000) @(posedge clock);
  endtask

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge clock) begin
    prev <= sqw_pin;
    if (sqw_pin && !prev)
      edges++;
    cyc++;
    if (cyc == 70000) begin
      err_count++;
      stop_test();
    end
  end

  initial begin
    rst = 1'b1;
    run = 1'b1;
    req = '0;
    prev = 1'b1;
    seed = 32'hae90;
    {err_count, tests_run, cyc, edges} = '0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rdb(8'h00, 14);
    cmp('{8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80});
    put(1'b1, 1'b0, 1'b0, 8'h10);
    #1 chk({7'h00, rsp.hit}, 8'h00);
    put(1'b1, 1'b0, 1'b0, 8'h0f);
    #1 chk({7'h00, rsp.hit}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      v = 8'(($unsigned($random(seed)) % 6) * 16 + $unsigned($random(seed)) % 10);
      wrb(8'h03, '{v});
      rdb(8'h03, 1);
      chk(got[0], v);
    end
    $display("test registers done");
    wrb(8'h02, '{8'h59, 8'h59, 8'h23, 8'h28, 8'h06, 8'h02, 8'h04});
    one_second();
    rdb(8'h02, 7);
    cmp('{8'h00, 8'h00, 8'h00, 8'h29, 8'h00, 8'h02, 8'h04});
    $display("test leap done");
    wrb(8'h09, '{8'h00, 8'h80, 8'h80, 8'h80});
    wrb(8'h01, '{8'h02});
    wrb(8'h02, '{8'h59, 8'h59, 8'h23, 8'h31, 8'h03, 8'h12, 8'h99});
    chk({7'h00, irq_pin}, 8'h01);
    one_second();
    rdb(8'h01, 8);
    cmp('{8'h0a, 8'h00, 8'h00, 8'h00, 8'h01, 8'h04, 8'h01, 8'h00});
    chk({7'h00, irq_pin}, 8'h00);
    wrb(8'h01, '{8'h0a});
    rdb(8'h01, 1);
    chk(got[0], 8'h0a);
    wrb(8'h01, '{8'h02});
    one_second();
    rdb(8'h01, 1);
    chk(got[0], 8'h02);
    chk({7'h00, irq_pin}, 8'h01);
    $display("test alarm done");
    for (int rs = 1; rs < 4; rs++) begin
      count_wave(8'h80 | 8'(rs));
      ex = 200000 / (48 * (1 << (5 * rs)));
      chk({7'h00, edges >= ex - 2 && edges <= ex + 2}, 8'h01);
    end
    count_wave(8'h01);
    chk(8'(edges), 8'h00);
    chk({7'h00, sqw_pin}, 8'h01);
    $display("test square wave done");
    run <= 1'b0;
    repeat (400) @(posedge clock);
    rdb(8'h02, 1);
    chk({7'h00, got[0][7]}, 8'h01);
    $display("test oscillator fail done");
    stop_test();
  end
endmodule

`default_nettype wire
